// file: src/aek_pkg.sv
// shared constants of the 128-bit ecb encryption core
package aek_pkg;
   localparam int         BLOCK_W          = 128;
   localparam int         NUM_ROUNDS       = 10;
   localparam int         KEY_SETUP_CYCLES = 10;
   localparam int         RK_WORDS         = NUM_ROUNDS + 1;
   localparam int         RK_AW            = 4;
   localparam int         CNT_W            = 4;
   localparam int         CBUF_DEPTH       = 8;
   localparam logic [7:0] RCON_FIRST       = 8'h01;
   localparam logic [7:0] GF_POLY          = 8'h1B;
endpackage

// file: src/aek_rkey_mem.sv
// round key store, one write port and one registered read port
`timescale 1ns/10ps
module aek_rkey_mem #(
   parameter int WIDTH = 128,
   parameter int DEPTH = 11,
   parameter int AW    = 4
) (
   input  wire logic             core_clk,
   input  wire logic             rstn,
   input  wire logic             clk_en,
   input  wire logic             we,
   input  wire logic [AW-1:0]    waddr,
   input  wire logic [WIDTH-1:0] wdata,
   input  wire logic [AW-1:0]    raddr,
   output logic      [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] mem      [DEPTH];
   logic [WIDTH-1:0] next_mem [DEPTH];
   logic [WIDTH-1:0] next_rdata;

   always_comb begin
      next_mem = mem;
      if (we && (int'(waddr) < DEPTH)) begin
         next_mem[waddr] = wdata;
      end
      // reads beyond the table give zero rather than x
      next_rdata = (int'(raddr) < DEPTH) ? mem[raddr] : '0;
   end

   // contents carry no reset: a key must be loaded before use
   always_ff @(posedge core_clk) begin
      if (clk_en) begin
         mem <= next_mem;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rdata <= '0;
      end else if (clk_en) begin
         rdata <= next_rdata;
      end
   end
endmodule

// file: src/aek_fifo.sv
// ciphertext buffer with valid/ready on both sides
`timescale 1ns/10ps
module aek_fifo #(
   parameter int WIDTH = 128,
   parameter int DEPTH = 8
) (
   input  wire logic             core_clk,
   input  wire logic             rstn,
   input  wire logic             clk_en,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem      [DEPTH];
   logic [WIDTH-1:0] next_mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic [AW-1:0]    next_wr_ptr;
   logic [AW-1:0]    next_rd_ptr;
   logic [AW:0]      next_count;
   logic             push;
   logic             pop;

   function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
      return (int'(p) == DEPTH - 1) ? '0 : AW'(p + 1'b1);
   endfunction

   assign in_ready  = (int'(count) < DEPTH);
   assign out_valid = (count != '0);
   assign out_data  = mem[rd_ptr];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      next_mem    = mem;
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count  = count;
      if (push) begin
         next_mem[wr_ptr] = in_data;
         next_wr_ptr      = ptr_inc(wr_ptr);
      end
      if (pop) begin
         next_rd_ptr = ptr_inc(rd_ptr);
      end
      if (push && !pop) begin
         next_count = (AW+1)'(count + 1'b1);
      end else if (pop && !push) begin
         next_count = (AW+1)'(count - 1'b1);
      end
   end

   always_ff @(posedge core_clk) begin
      if (clk_en) begin
         mem <= next_mem;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else if (clk_en) begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
   end
endmodule

// file: src/aek_core.sv
// 128-bit key ecb encryption core: key setup, round engine, output buffer
// Operation
// - each 128-bit block is enciphered alone with the loaded 128-bit key
// - every block takes the same fixed number of cycles
// - reset is active low and returns the core to idle
// - key strobe while idle captures the key and starts key setup
// - key busy rises after key acceptance and holds through setup's last cycle
// - while key busy, both strobes are ignored
// - key done pulses high for the last cycle of key setup
// - key setup finishes ten cycles after the key strobe is taken
// - the last loaded key serves every later block until replaced or reset
// - plaintext strobe while ready (idle, key loaded, buffer slot free) and with no key strobe captures the block and starts encryption
// - encrypt busy rises after acceptance and holds through the last round
// - while encrypt busy, both strobes are ignored
// - encrypt done pulses high for the last cycle of each block
// - on completion ciphertext is driven with its valid flag
// - encrypt busy starts next cycle and stays high ten cycles
`timescale 1ns/10ps
module aek_core
   import aek_pkg::*;
#(
   parameter int CBUF_D = CBUF_DEPTH
) (
   input  wire logic               core_clk,
   input  wire logic               rstn,
   input  wire logic               clk_en,
   input  wire logic               key_load_strobe,
   input  wire logic [BLOCK_W-1:0] key_word,
   output logic                    key_setup_busy,
   output logic                    key_setup_done,
   input  wire logic               plaintext_strobe,
   input  wire logic [BLOCK_W-1:0] plaintext_block,
   output logic                    plaintext_ready,
   output logic                    encrypt_busy,
   output logic                    encrypt_done,
   output logic                    ciphertext_valid,
   output logic      [BLOCK_W-1:0] ciphertext_block,
   output logic                    cbuf_valid,
   input  wire logic               cbuf_ready,
   output logic      [BLOCK_W-1:0] cbuf_data
);

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_KEY,
      ST_ENC
   } aek_state_t;

   // forward substitution table, entry 0 in the top byte
   localparam logic [2047:0] SBOX_TAB = {
      128'h637C777BF26B6FC53001672BFED7AB76,
      128'hCA82C97DFA5947F0ADD4A2AF9CA472C0,
      128'hB7FD9326363FF7CC34A5E5F171D83115,
      128'h04C723C31896059A071280E2EB27B275,
      128'h09832C1A1B6E5AA0523BD6B329E32F84,
      128'h53D100ED20FCB15B6ACBBE394A4C58CF,
      128'hD0EFAAFB434D338545F9027F503C9FA8,
      128'h51A3408F929D38F5BCB6DA2110FFF3D2,
      128'hCD0C13EC5F974417C4A77E3D645D1973,
      128'h60814FDC222A908846EEB814DE5E0BDB,
      128'hE0323A0A4906245CC2D3AC629195E479,
      128'hE7C8376D8DD54EA96C56F4EA657AAE08,
      128'hBA78252E1CA6B4C6E8DD741F4BBD8B8A,
      128'h703EB5664803F60E613557B986C11D9E,
      128'hE1F8981169D98E949B1E87E9CE5528DF,
      128'h8CA1890DBFE6426841992D0FB054BB16
   };

   // counts start at zero, so the last cycle is one short of the span
   localparam logic [CNT_W-1:0] KEY_LAST = CNT_W'(KEY_SETUP_CYCLES - 1);
   localparam logic [CNT_W-1:0] ENC_LAST = CNT_W'(NUM_ROUNDS - 1);

   // a table keeps the lookup obvious; a field-inverse form would be smaller
   function automatic logic [7:0] sbox(input logic [7:0] b);
      return SBOX_TAB[8 * (255 - int'(b)) +: 8];
   endfunction

   function automatic logic [7:0] xtime(input logic [7:0] b);
      return {b[6:0], 1'b0} ^ (b[7] ? GF_POLY : 8'h00);
   endfunction

   function automatic logic [31:0] sub_word(input logic [31:0] w);
      return {sbox(w[31:24]), sbox(w[23:16]), sbox(w[15:8]), sbox(w[7:0])};
   endfunction

   // xtime form keeps the column mix to shifts and xors
   function automatic logic [31:0] mix_col(input logic [31:0] c);
      logic [7:0] a0;
      logic [7:0] a1;
      logic [7:0] a2;
      logic [7:0] a3;
      a0 = c[31:24];
      a1 = c[23:16];
      a2 = c[15:8];
      a3 = c[7:0];
      return {xtime(a0) ^ xtime(a1) ^ a1 ^ a2 ^ a3,
              a0 ^ xtime(a1) ^ xtime(a2) ^ a2 ^ a3,
              a0 ^ a1 ^ xtime(a2) ^ xtime(a3) ^ a3,
              xtime(a0) ^ a0 ^ a1 ^ a2 ^ xtime(a3)};
   endfunction

   // next round key from the previous one, words in big-endian order
   function automatic logic [BLOCK_W-1:0] key_expand(input logic [BLOCK_W-1:0] rk,
                                                     input logic [7:0]         rcon);
      logic [31:0] t;
      logic [31:0] n0;
      logic [31:0] n1;
      logic [31:0] n2;
      logic [31:0] n3;
      t  = sub_word({rk[23:0], rk[31:24]}) ^ {rcon, 24'h000000};
      n0 = rk[127:96] ^ t;
      n1 = rk[95:64] ^ n0;
      n2 = rk[63:32] ^ n1;
      n3 = rk[31:0] ^ n2;
      return {n0, n1, n2, n3};
   endfunction

   // one cipher round; byte i sits at bits 127-8i, column-major
   function automatic logic [BLOCK_W-1:0] enc_round(input logic [BLOCK_W-1:0] s,
                                                    input logic [BLOCK_W-1:0] rk,
                                                    input logic               last);
      logic [BLOCK_W-1:0] sr;
      logic [BLOCK_W-1:0] mc;
      int                 src;
      sr = '0;
      mc = '0;
      for (int i = 0; i < 16; i++) begin
         src = (i % 4) + 4 * (((i / 4) + (i % 4)) % 4);
         sr[127 - 8 * i -: 8] = sbox(s[127 - 8 * src -: 8]);
      end
      for (int c = 0; c < 4; c++) begin
         mc[127 - 32 * c -: 32] = mix_col(sr[127 - 32 * c -: 32]);
      end
      return (last ? sr : mc) ^ rk;
   endfunction

   // sequencing
   aek_state_t         state;
   aek_state_t         next_state;
   logic [CNT_W-1:0]   cnt;
   logic [CNT_W-1:0]   next_cnt;
   logic               key_take;
   logic               blk_take;

   // key schedule
   logic [BLOCK_W-1:0] key_reg;
   logic [BLOCK_W-1:0] next_key_reg;
   logic [BLOCK_W-1:0] rk_cur;
   logic [BLOCK_W-1:0] next_rk_cur;
   logic [7:0]         rcon;
   logic [7:0]         next_rcon;
   logic               key_loaded;
   logic               next_key_loaded;
   logic [BLOCK_W-1:0] expanded;

   // cipher state and result
   logic [BLOCK_W-1:0] blk;
   logic [BLOCK_W-1:0] next_blk;
   logic [BLOCK_W-1:0] rounded;
   logic               next_ct_valid;
   logic [BLOCK_W-1:0] next_ct_block;

   // round key store and output buffer
   logic               rk_we;
   logic [RK_AW-1:0]   rk_waddr;
   logic [BLOCK_W-1:0] rk_wdata;
   logic [RK_AW-1:0]   rk_raddr;
   logic [BLOCK_W-1:0] rk_rdata;
   logic               cbuf_in_ready;

   assign key_setup_busy  = (state == ST_KEY);
   assign encrypt_busy    = (state == ST_ENC);
   assign key_setup_done  = (state == ST_KEY) && (cnt == KEY_LAST);
   assign encrypt_done    = (state == ST_ENC) && (cnt == ENC_LAST);
   // a block is taken while the buffer has a slot free, even if a result fills that slot the same cycle
   assign plaintext_ready = (state == ST_IDLE) && key_loaded && cbuf_in_ready;
   assign key_take        = (state == ST_IDLE) && key_load_strobe;
   assign blk_take        = plaintext_strobe && plaintext_ready && !key_load_strobe;
   assign expanded        = key_expand(rk_cur, rcon);
   assign rounded         = enc_round(blk, rk_rdata, cnt == ENC_LAST);

   always_comb begin
      next_state      = state;
      next_cnt        = cnt;
      next_key_reg    = key_reg;
      next_rk_cur     = rk_cur;
      next_rcon       = rcon;
      next_blk        = blk;
      next_key_loaded = key_loaded;
      next_ct_valid   = 1'b0;
      next_ct_block   = ciphertext_block;

      // idle store port reads key 1, so the first round finds it waiting
      rk_we           = 1'b0;
      rk_waddr        = '0;
      rk_wdata        = key_word;
      rk_raddr        = RK_AW'(1);
      unique case (state)
         ST_IDLE: begin
            // key strobe wins when both strobes arrive together
            if (key_take) begin
               next_state   = ST_KEY;
               next_key_reg = key_word;
               next_rk_cur  = key_word;
               next_rcon    = RCON_FIRST;
               next_cnt     = '0;
               rk_we        = 1'b1;
            end else if (blk_take) begin
               next_state = ST_ENC;
               next_blk   = plaintext_block ^ key_reg;
               next_cnt   = '0;
            end
         end

         ST_KEY: begin
            // strobes are not looked at while setting up
            rk_we       = 1'b1;
            rk_waddr    = RK_AW'(cnt + 1'b1);
            rk_wdata    = expanded;
            next_rk_cur = expanded;
            next_rcon   = xtime(rcon);
            next_cnt    = CNT_W'(cnt + 1'b1);
            if (cnt == KEY_LAST) begin
               next_state      = ST_IDLE;
               next_key_loaded = 1'b1;
            end
         end

         ST_ENC: begin
            // fixed round count, no early exit, so latency never varies
            next_blk = rounded;
            // the store read is registered, so fetch one round ahead
            rk_raddr = RK_AW'(cnt + 2'd2);
            next_cnt = CNT_W'(cnt + 1'b1);
            if (cnt == ENC_LAST) begin
               next_state    = ST_IDLE;
               next_ct_valid = 1'b1;
               next_ct_block = rounded;
            end
         end

         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state            <= ST_IDLE;
         cnt              <= '0;
         key_reg          <= '0;
         rk_cur           <= '0;
         rcon             <= RCON_FIRST;
         blk              <= '0;
         key_loaded       <= 1'b0;
         ciphertext_valid <= 1'b0;
         ciphertext_block <= '0;
      end else if (clk_en) begin
         state            <= next_state;
         cnt              <= next_cnt;
         key_reg          <= next_key_reg;
         rk_cur           <= next_rk_cur;
         rcon             <= next_rcon;
         blk              <= next_blk;
         key_loaded       <= next_key_loaded;
         ciphertext_valid <= next_ct_valid;
         ciphertext_block <= next_ct_block;
      end
   end

   // keys are expanded once per key load, not once per block
   aek_rkey_mem #(
      .WIDTH (BLOCK_W),
      .DEPTH (RK_WORDS),
      .AW    (RK_AW)
   ) u_rkey (
      .core_clk (core_clk),
      .rstn     (rstn),
      .clk_en   (clk_en),
      .we       (rk_we),
      .waddr    (rk_waddr),
      .wdata    (rk_wdata),
      .raddr    (rk_raddr),
      .rdata    (rk_rdata)
   );

   // depth sets how far the consumer may lag before new blocks stall
   aek_fifo #(
      .WIDTH (BLOCK_W),
      .DEPTH (CBUF_D)
   ) u_cbuf (
      .core_clk  (core_clk),
      .rstn      (rstn),
      .clk_en    (clk_en),
      .in_valid  (ciphertext_valid),
      .in_ready  (cbuf_in_ready),
      .in_data   (ciphertext_block),
      .out_valid (cbuf_valid),
      .out_ready (cbuf_ready),
      .out_data  (cbuf_data)
   );
endmodule

// file: tb/aek_core_monitor.sv
// port checker for the encryption core
`timescale 1ns/10ps
module aek_core_monitor
   import aek_pkg::*;
(
   input  wire logic               core_clk,
   input  wire logic               rstn,
   input  wire logic               clk_en,
   input  wire logic               key_load_strobe,
   input  wire logic               key_setup_busy,
   input  wire logic               key_setup_done,
   input  wire logic               plaintext_strobe,
   input  wire logic               plaintext_ready,
   input  wire logic               encrypt_busy,
   input  wire logic               encrypt_done,
   input  wire logic               ciphertext_valid,
   input  wire logic [BLOCK_W-1:0] ciphertext_block
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   logic idle;
   assign idle = !key_setup_busy && !encrypt_busy;

   key_span_a: assert property (
      clk_en && idle && key_load_strobe |=>
      key_setup_busy [*5] ##1 key_setup_busy [*5] ##1 !key_setup_busy)
      else $error("key setup busy span wrong");
   key_done_a: assert property (
      key_setup_done |-> key_setup_busy ##1 (!key_setup_busy && !key_setup_done))
      else $error("key done not on last busy cycle");
   enc_span_a: assert property (
      clk_en && idle && plaintext_strobe && plaintext_ready && !key_load_strobe |=>
      encrypt_busy [*5] ##1 encrypt_busy [*5] ##1 (!encrypt_busy && ciphertext_valid))
      else $error("encrypt busy span wrong");
   enc_done_a: assert property (
      encrypt_done |-> encrypt_busy ##1 (ciphertext_valid && !encrypt_busy && !encrypt_done))
      else $error("encrypt done not followed by result");
   key_ignore_a: assert property (
      key_setup_busy && !key_setup_done |=> key_setup_busy && !encrypt_busy)
      else $error("strobe taken during key setup");
   enc_ignore_a: assert property (
      encrypt_busy && !encrypt_done |=> encrypt_busy && !key_setup_busy)
      else $error("strobe taken during encryption");
   result_hold_a: assert property (
      !ciphertext_valid |-> $stable(ciphertext_block))
      else $error("ciphertext changed without valid");
   reset_quiet_a: assert property (
      $rose(rstn) |-> !(key_setup_busy || key_setup_done || encrypt_busy || encrypt_done
      || ciphertext_valid || plaintext_ready))
      else $error("outputs not quiet after reset");
   ready_idle_a: assert property (
      plaintext_ready |-> idle)
      else $error("ready while busy");
   key_load_c: cover property (key_setup_done);
   back_to_back_c: cover property (encrypt_done ##1 plaintext_strobe ##1 encrypt_busy);
   buf_full_c: cover property (encrypt_done ##2 (idle && !plaintext_ready));
endmodule
bind aek_core aek_core_monitor u_aek_core_monitor (
   .core_clk(core_clk), .rstn(rstn), .clk_en(clk_en), .key_load_strobe(key_load_strobe),
   .key_setup_busy(key_setup_busy), .key_setup_done(key_setup_done),
   .plaintext_strobe(plaintext_strobe), .plaintext_ready(plaintext_ready),
   .encrypt_busy(encrypt_busy), .encrypt_done(encrypt_done),
   .ciphertext_valid(ciphertext_valid), .ciphertext_block(ciphertext_block)
);

// file: tb/aek_sink.sv
// ciphertext buffer consumer, prompt or slow, can stall completely
`timescale 1ns/10ps
module aek_sink
   import aek_pkg::*;
(
   input  wire logic               core_clk,
   input  wire logic               rstn,
   input  wire logic               hold,
   input  wire logic               slow,
   input  wire logic               cbuf_valid,
   input  wire logic [BLOCK_W-1:0] cbuf_data,
   output logic                    cbuf_ready,
   output logic                    pop,
   output logic      [BLOCK_W-1:0] pop_data
);
   logic [2:0] ph;
   // ready moves on the falling edge so the core never samples it mid-change
   always @(negedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ph <= 3'h0;
         cbuf_ready <= 1'b0;
      end else begin
         ph <= ph + 3'h1;
         cbuf_ready <= !hold && (!slow || ph == 3'h5);
      end
   end
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pop <= 1'b0;
      end else begin
         pop <= cbuf_valid && cbuf_ready;
         pop_data <= cbuf_data;
      end
   end
endmodule

// file: tb/tb_aek_core.sv
// self-checking bench for the encryption core with a reference cipher model
`timescale 1ns/10ps
module tb_aek_core;
   import aek_pkg::*;
   logic               core_clk, rstn, clk_en, hold, slow, pop;
   logic               key_load_strobe, plaintext_strobe, cbuf_ready, cbuf_valid;
   logic               key_setup_busy, key_setup_done, plaintext_ready;
   logic               encrypt_busy, encrypt_done, ciphertext_valid;
   logic [BLOCK_W-1:0] key_word, plaintext_block, ciphertext_block, cbuf_data, pop_data, key_m;
   logic [BLOCK_W-1:0] buf_q [$];
   logic [7:0]         sb [256];
   logic [31:0]        seed = 32'h0001_2A1C;
   int                 fail_count = 0;
   int                 cmp_count = 0;

   aek_core u_aek_core (.core_clk(core_clk), .rstn(rstn), .clk_en(clk_en),
      .key_load_strobe(key_load_strobe), .key_word(key_word), .key_setup_busy(key_setup_busy),
      .key_setup_done(key_setup_done), .plaintext_strobe(plaintext_strobe),
      .plaintext_block(plaintext_block), .plaintext_ready(plaintext_ready),
      .encrypt_busy(encrypt_busy), .encrypt_done(encrypt_done),
      .ciphertext_valid(ciphertext_valid), .ciphertext_block(ciphertext_block),
      .cbuf_valid(cbuf_valid), .cbuf_ready(cbuf_ready), .cbuf_data(cbuf_data));
   aek_sink u_aek_sink (.core_clk(core_clk), .rstn(rstn), .hold(hold), .slow(slow),
      .cbuf_valid(cbuf_valid), .cbuf_data(cbuf_data), .cbuf_ready(cbuf_ready),
      .pop(pop), .pop_data(pop_data));

   function automatic logic [7:0] xt(input logic [7:0] a);
      return {a[6:0], 1'b0} ^ (a[7] ? GF_POLY : 8'h00);
   endfunction
   function automatic logic [7:0] gm(input logic [7:0] a, input logic [7:0] b);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 0; i < 8; i++) begin
         if (b[i]) r ^= a;
         a = xt(a);
      end
      return r;
   endfunction
   function automatic logic [31:0] nx(input logic [31:0] q);
      return {q[30:0], 1'b0} ^ (q[31] ? 32'h04C1_1DB7 : 32'h0000_0000);
   endfunction
   // straight round-by-round cipher, slow but independent of the core's key store
   function automatic logic [127:0] enc(input logic [127:0] k, input logic [127:0] pt);
      logic [31:0] w [44];
      logic [7:0]  s [16];
      logic [7:0]  t [16];
      logic [7:0]  rc;
      logic [31:0] x;
      logic [127:0] o;
      int          c;
      rc = RCON_FIRST;
      for (int i = 0; i < 44; i++) begin
         x = (i < 4) ? k[127 - 32 * i -: 32] : w[i - 1];
         if (i >= 4 && i % 4 == 0) begin
            x = {sb[x[23:16]], sb[x[15:8]], sb[x[7:0]], sb[x[31:24]]} ^ {rc, 24'h000000};
            rc = xt(rc);
         end
         w[i] = (i < 4) ? x : w[i - 4] ^ x;
      end
      for (int i = 0; i < 16; i++) s[i] = pt[127 - 8 * i -: 8] ^ w[i / 4][31 - 8 * (i % 4) -: 8];
      for (int r = 1; r <= NUM_ROUNDS; r++) begin
         for (int i = 0; i < 16; i++) t[i] = sb[s[(i + 4 * (i % 4)) % 16]];
         for (int i = 0; i < 16; i++) begin
            c = i - i % 4;
            s[i] = (r == NUM_ROUNDS) ? t[i] : xt(t[i]) ^ xt(t[c + (i + 1) % 4])
                   ^ t[c + (i + 1) % 4] ^ t[c + (i + 2) % 4] ^ t[c + (i + 3) % 4];
            s[i] ^= w[4 * r + i / 4][31 - 8 * (i % 4) -: 8];
         end
      end
      for (int i = 0; i < 16; i++) o[127 - 8 * i -: 8] = s[i];
      return o;
   endfunction

   task automatic rnd(output logic [127:0] v);
      v = 128'h0;
      repeat (4) begin
         seed = nx(seed);
         v = {v[95:0], seed};
      end
   endtask
   task automatic chk_bit(input string n, input logic e, input logic g);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_blk(input string n, input logic [127:0] e, input logic [127:0] g);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic summarize();
      if (fail_count == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // one key load or block; poke keeps both strobes up with junk while busy, dropping them for the last busy cycle
   task automatic run(input logic k_op, input logic [127:0] v, input logic poke);
      logic [127:0] junk;
      rnd(junk);
      key_load_strobe = k_op;
      plaintext_strobe = !k_op;
      key_word = k_op ? v : junk;
      plaintext_block = v;
      @(negedge core_clk);
      key_load_strobe = poke;
      plaintext_strobe = poke;
      key_word = junk;
      plaintext_block = junk;
      for (int i = 1; i <= 10; i++) begin
         chk_bit("busy", 1'b1, k_op ? key_setup_busy : encrypt_busy);
         chk_bit("done", i == 10, k_op ? key_setup_done : encrypt_done);
         chk_bit("other busy", 1'b0, k_op ? encrypt_busy : key_setup_busy);
         if (i == 10) begin
            key_load_strobe = 1'b0;
            plaintext_strobe = 1'b0;
         end
         @(negedge core_clk);
      end
      chk_bit("busy end", 1'b0, key_setup_busy | encrypt_busy);
      chk_bit("valid", !k_op, ciphertext_valid);
      if (k_op) key_m = v;
      else begin
         chk_blk("cipher", enc(key_m, v), ciphertext_block);
         buf_q.push_back(enc(key_m, v));
      end
   endtask
   task automatic refuse();
      plaintext_strobe = 1'b1;
      rnd(plaintext_block);
      @(negedge core_clk);
      plaintext_strobe = 1'b0;
      chk_bit("refused", 1'b0, encrypt_busy);
      @(negedge core_clk);
   endtask

   always @(negedge core_clk)
      if (pop === 1'b1) chk_blk("buffer", buf_q.pop_front(), pop_data);
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   initial begin
      repeat (6000) @(posedge core_clk);
      fail_count++;
      summarize();
   end
   initial begin
      logic [7:0]   p;
      logic [127:0] v;
      {rstn, key_load_strobe, plaintext_strobe, hold, slow} = 5'h00;
      {clk_en, key_word, plaintext_block, key_m} = {1'b1, 384'h0};
      for (int x = 0; x < 256; x++) begin
         p = 8'h01;
         repeat (254) p = gm(p, x[7:0]);
         sb[x] = p ^ {p[6:0], p[7]} ^ {p[5:0], p[7:6]} ^ {p[4:0], p[7:5]} ^ {p[3:0], p[7:4]} ^ 8'h63;
      end
      repeat (4) @(negedge core_clk);
      chk_bit("reset quiet", 1'b0, key_setup_busy | encrypt_busy | ciphertext_valid);
      rstn = 1'b1;
      refuse();
      run(1'b1, 128'h0001_0203_0405_0607_0809_0A0B_0C0D_0E0F, 1'b1);
      run(1'b0, 128'h0011_2233_4455_6677_8899_AABB_CCDD_EEFF, 1'b0);
      chk_blk("known", 128'h69C4_E0D8_6A7B_0430_D8CD_B780_70B4_C55A, ciphertext_block);
      slow = 1'b1;
      for (int i = 0; i < 8; i++) begin
         rnd(v);
         run(i == 4, v, i[0]);
      end
      // the full buffer check relies on an empty buffer first
      for (int n = 0; n < 300 && buf_q.size() > 0; n++) @(negedge core_clk);
      hold = 1'b1;
      for (int i = 0; i < CBUF_DEPTH; i++) begin
         rnd(v);
         run(1'b0, v, 1'b0);
      end
      @(negedge core_clk);
      chk_bit("ready full", 1'b0, plaintext_ready);
      refuse();
      hold = 1'b0;
      for (int n = 0; n < 300 && buf_q.size() > 0; n++) @(negedge core_clk);
      chk_bit("drained", 1'b0, cbuf_valid);
      rnd(v);
      run(1'b1, v, 1'b0);
      plaintext_strobe = 1'b1;
      @(negedge core_clk);
      plaintext_strobe = 1'b0;
      repeat (3) @(negedge core_clk);
      rstn = 1'b0;
      #1 chk_bit("mid reset", 1'b0, encrypt_busy | ciphertext_valid | plaintext_ready);
      @(negedge core_clk);
      rstn = 1'b1;
      buf_q.delete();
      refuse();
      run(1'b1, 128'h0001_0203_0405_0607_0809_0A0B_0C0D_0E0F, 1'b0);
      run(1'b0, 128'h0011_2233_4455_6677_8899_AABB_CCDD_EEFF, 1'b0);
      repeat (20) @(negedge core_clk);
      chk_bit("all popped", 1'b1, buf_q.size() == 0);
      // a frozen core must not take a strobe it would otherwise accept
      clk_en = 1'b0;
      plaintext_strobe = 1'b1;
      repeat (2) @(negedge core_clk);
      chk_bit("ready", 1'b1, plaintext_ready);
      chk_bit("frozen", 1'b0, encrypt_busy);
      clk_en = 1'b1;
      plaintext_strobe = 1'b0;
      @(negedge core_clk);
      chk_bit("thawed", 1'b0, encrypt_busy);
      summarize();
   end
endmodule
